// File: src/sid_lamps.sv
// Front-panel status lamp driver: power, link/activity, run and error lamps
//
// Contract
// - Power lamp lit steadily while unit power is present, dark otherwise.
// - Input port lamp: dark no link, steady linked, flicker with traffic.
// - Output port lamp follows the same dark, steady, flicker scheme.
// - Run lamp: Init dark, Pre-Op blink, Safe-Op single flash, Op steady.
// - Error lamp: blink, double flash, flicker, steady by error class.
// - Error lamp single flash for synchronization or communications data error.
module sid_lamps
  import sid_pkg::*;
(
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RESET_N,
  input  wire logic       i_power_good,
  input  wire logic       i_in_link,
  input  wire logic       i_in_activity,
  input  wire logic       i_out_link,
  input  wire logic       i_out_activity,
  input  wire logic [1:0] i_slave_state,
  input  wire sid_err_t   i_err,
  output logic            o_power_lamp,
  output logic            o_in_link_lamp,
  output logic            o_out_link_lamp,
  output logic            o_run_lamp,
  output logic            o_err_lamp
);

  // Pin-level inputs pass two flops before use
  localparam int unsigned NIN = 13;

  // Error classes in rising order of severity
  typedef enum logic [2:0]
  {
    SID_ERR_NONE  = 3'h0,
    SID_ERR_CFG   = 3'h1,
    SID_ERR_SYNC  = 3'h2,
    SID_ERR_APP   = 3'h3,
    SID_ERR_BOOT  = 3'h4,
    SID_ERR_LOCAL = 3'h5
  } sid_err_class_t;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync1_nxt;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] sync2_nxt;
  logic           power_good;
  logic           in_link;
  logic           in_activity;
  logic           out_link;
  logic           out_activity;
  logic [1:0]     state_seen_r;
  logic [1:0]     state_seen_nxt;
  sid_state_t     state_r;
  sid_state_t     state_nxt;
  sid_err_t       err;
  sid_err_class_t err_class;
  sid_pat_t       pat;
  logic           power_lamp_r;
  logic           power_lamp_nxt;
  logic           in_lamp_r;
  logic           in_lamp_nxt;
  logic           out_lamp_r;
  logic           out_lamp_nxt;
  logic           run_lamp_r;
  logic           run_lamp_nxt;
  logic           err_lamp_r;
  logic           err_lamp_nxt;

  assign raw = {i_power_good, i_in_link, i_in_activity, i_out_link, i_out_activity,
                i_slave_state, i_err};

  always_comb
  begin
    sync1_nxt = raw;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign {power_good, in_link, in_activity, out_link, out_activity} = sync2_r[12:8];
  assign err = sid_err_t'(sync2_r[5:0]);

  sid_patgen u_patgen
  (
    .i_clk     (I_CORE_CLK),
    .i_reset_n (I_RESET_N),
    .o_pat     (pat)
  );

  // Pre-Op to Safe-Op flips both state bits; as they settle apart a false
  // code could pass, so a code is taken only when two samples in a row agree
  always_comb
  begin
    state_seen_nxt = sync2_r[7:6];
    state_nxt      = state_r;
    if (sync2_r[7:6] == state_seen_r)
    begin
      state_nxt = sid_state_t'(sync2_r[7:6]);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_seen_r <= SYNC_RST;
      state_r      <= SID_INIT;
    end
    else
    begin
      state_seen_r <= state_seen_nxt;
      state_r      <= state_nxt;
    end
  end

  // Most severe class wins when several errors are raised at once
  always_comb
  begin
    if (err.local_interface_watchdog)
      err_class = SID_ERR_LOCAL;
    else if (err.boot_err)
      err_class = SID_ERR_BOOT;
    else if (err.app_watchdog)
      err_class = SID_ERR_APP;
    else if (err.sync_err || err.data_err)
      err_class = SID_ERR_SYNC;
    else if (err.cfg_err)
      err_class = SID_ERR_CFG;
    else
      err_class = SID_ERR_NONE;
  end

  always_comb
  begin
    power_lamp_nxt = power_good;
    // Traffic only counts on an established link
    in_lamp_nxt    = in_link & (in_activity ? pat.flicker : 1'b1);
    out_lamp_nxt   = out_link & (out_activity ? pat.flicker : 1'b1);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      power_lamp_r <= 1'b0;
      in_lamp_r    <= 1'b0;
      out_lamp_r   <= 1'b0;
    end
    else
    begin
      power_lamp_r <= power_lamp_nxt;
      in_lamp_r    <= in_lamp_nxt;
      out_lamp_r   <= out_lamp_nxt;
    end
  end

  // Reads the filter's next value, so the state costs only one extra edge
  always_comb
  begin
    unique case (state_nxt)
      SID_INIT:    run_lamp_nxt = 1'b0;
      SID_PRE_OP:  run_lamp_nxt = pat.blink;
      SID_SAFE_OP: run_lamp_nxt = pat.single_flash;
      SID_OP:      run_lamp_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      run_lamp_r <= 1'b0;
    end
    else
    begin
      run_lamp_r <= run_lamp_nxt;
    end
  end

  always_comb
  begin
    unique case (err_class)
      SID_ERR_NONE:  err_lamp_nxt = 1'b0;
      SID_ERR_CFG:   err_lamp_nxt = pat.blink;
      SID_ERR_SYNC:  err_lamp_nxt = pat.single_flash;
      SID_ERR_APP:   err_lamp_nxt = pat.double_flash;
      SID_ERR_BOOT:  err_lamp_nxt = pat.flicker;
      SID_ERR_LOCAL: err_lamp_nxt = 1'b1;
      default:       err_lamp_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      err_lamp_r <= 1'b0;
    end
    else
    begin
      err_lamp_r <= err_lamp_nxt;
    end
  end

  assign o_power_lamp    = power_lamp_r;
  assign o_in_link_lamp  = in_lamp_r;
  assign o_out_link_lamp = out_lamp_r;
  assign o_run_lamp      = run_lamp_r;
  assign o_err_lamp      = err_lamp_r;

endmodule

// File: src/sid_patgen.sv
// Shared time base producing the indicator flash patterns
module sid_patgen
  import sid_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  output sid_pat_t      o_pat
);

  logic [22:0] div_r;
  logic [22:0] div_nxt;
  logic [4:0]  step_r;
  logic [4:0]  step_nxt;
  logic [4:0]  sstep_r;
  logic [4:0]  sstep_nxt;
  logic        flk_r;
  logic        flk_nxt;
  sid_pat_t    pat_r;
  sid_pat_t    pat_nxt;

  always_comb
  begin
    div_nxt   = div_r + 23'h000001;
    step_nxt  = step_r;
    sstep_nxt = sstep_r;
    flk_nxt   = flk_r;
    if (div_r == STEP_LAST)
    begin
      div_nxt   = 23'h000000;
      flk_nxt   = ~flk_r;
      step_nxt  = (step_r == FRAME_LAST) ? 5'h00 : step_r + 5'h01;
      sstep_nxt = (sstep_r == SINGLE_LAST) ? 5'h00 : sstep_r + 5'h01;
    end
    pat_nxt.flicker      = flk_r;
    // Blink runs free, 200 ms on and off; the frame is a whole number of its periods
    pat_nxt.blink        = (step_r % (BLINK_LEN << 1)) < BLINK_LEN;
    // Single flash keeps its own shorter frame so its gap is the 1000 ms one
    pat_nxt.single_flash = (sstep_r < BLINK_LEN);
    pat_nxt.double_flash = (step_r < BLINK_LEN) ||
                           ((step_r >= FLASH2_BEG) && (step_r < FLASH2_END));
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div_r  <= 23'h000000;
      step_r <= 5'h00;
      sstep_r <= 5'h00;
      flk_r  <= 1'b0;
      pat_r  <= '0;
    end
    else
    begin
      div_r  <= div_nxt;
      step_r <= step_nxt;
      sstep_r <= sstep_nxt;
      flk_r  <= flk_nxt;
      pat_r  <= pat_nxt;
    end
  end

  assign o_pat = pat_r;

endmodule

// File: src/sid_pkg.sv
// Shared constants and carrier types for the status lamp driver
package sid_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // Indicator pattern times in milliseconds
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned BLINK_MS   = 200;
  localparam int unsigned GAP_MS     = 1000;

  // One pattern step is the 50 ms flicker phase; other times are multiples of it
  localparam int unsigned STEP_CYC   = (CLK_HZ / 1000) * FLICKER_MS;
  localparam int unsigned BLINK_STEPS = BLINK_MS / FLICKER_MS;
  localparam int unsigned GAP_STEPS   = GAP_MS / FLICKER_MS;
  // Frame: flash 200 on, 200 off, flash 200 on, then 1000 off
  localparam int unsigned FRAME_STEPS = 3 * BLINK_STEPS + GAP_STEPS;

  localparam logic [22:0] STEP_LAST  = 23'(STEP_CYC - 1);
  localparam logic [4:0]  FRAME_LAST = 5'(FRAME_STEPS - 1);
  localparam logic [4:0]  BLINK_LEN  = 5'(BLINK_STEPS);
  localparam logic [4:0]  FLASH2_BEG = 5'(2 * BLINK_STEPS);
  localparam logic [4:0]  FLASH2_END = 5'(3 * BLINK_STEPS);
  // Single flash frame: flash 200 on, then 1000 off
  localparam logic [4:0]  SINGLE_LAST = 5'(BLINK_STEPS + GAP_STEPS - 1);
  localparam logic [1:0]  SYNC_RST   = 2'h0;

  typedef enum logic [1:0]
  {
    SID_INIT     = 2'h0,
    SID_PRE_OP   = 2'h1,
    SID_SAFE_OP  = 2'h2,
    SID_OP       = 2'h3
  } sid_state_t;

  typedef struct packed
  {
    logic cfg_err;
    logic sync_err;
    logic data_err;
    logic app_watchdog;
    logic boot_err;
    logic local_interface_watchdog;
  } sid_err_t;

  typedef struct packed
  {
    logic flicker;
    logic blink;
    logic single_flash;
    logic double_flash;
  } sid_pat_t;

endpackage

// File: verif/sid_lamp_panel.sv
// Lamp panel as an operator sees it
module sid_lamp_panel
(
  input  wire logic       I_CORE_CLK,
  input  wire logic [4:0] i_lamps,
  output logic      [4:0] o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Eye samples once a cycle; costs one edge of lag
  always_ff @(posedge I_CORE_CLK) o_seen <= i_lamps;
endmodule

// File: verif/sid_lamps_bench.sv
// Self-checking bench for the status lamp driver
module sid_lamps_bench
  import sid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CORE_CLK = 1'b0;
  logic        I_RESET_N  = 1'b0;
  logic [12:0] s          = 13'h0000;
  logic [4:0]  seen;
  wire  [4:0]  lamps;
  int          mismatches = 0;
  int          checks     = 0;
  int          cyc        = 0;
  always #4 I_CORE_CLK = ~I_CORE_CLK;
  sid_lamps u_sid_lamps (.I_CORE_CLK, .I_RESET_N, .i_power_good(s[12]), .i_in_link(s[11]),
    .i_in_activity(s[10]), .i_out_link(s[9]), .i_out_activity(s[8]), .i_slave_state(s[7:6]),
    .i_err(sid_err_t'(s[5:0])), .o_power_lamp(lamps[4]), .o_in_link_lamp(lamps[3]),
    .o_out_link_lamp(lamps[2]), .o_run_lamp(lamps[1]), .o_err_lamp(lamps[0]));
  sid_lamp_panel u_sid_lamp_panel (.I_CORE_CLK, .i_lamps(lamps), .o_seen(seen));
  // Run stays inside the first 50 ms step: flicker dark, flash patterns in their on phase
  function automatic logic [4:0] expf(input logic [12:0] v);
    return {v[12], v[11] & ~v[10], v[9] & ~v[8], |v[7:6], v[0] | (~v[1] & |v[5:2])};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic expect_lamps(input logic [4:0] want);
    checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED lamps exp %b got %b", want, seen);
    end
  endtask
  task automatic apply(input logic [12:0] v);
    @(negedge I_CORE_CLK) s = v;
    repeat (6) @(negedge I_CORE_CLK);
    expect_lamps(expf(v));
  endtask
  always @(posedge I_CORE_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(15));
    repeat (4) @(negedge I_CORE_CLK);
    I_RESET_N = 1'b1;
    for (int st = 0; st < 4; st++)
      apply({5'b11010, 2'(st), 6'h00});
    apply(13'h0500);
    for (int i = 0; i < 6; i++)
      apply(13'h1000 | 13'(1 << i));
    apply(13'h1003);
    apply(13'h1026);
    repeat (40) apply(13'($urandom));
    apply(13'h1AC0);
    // Mid-run reset: lamps dark at once, and dark while the inputs resync
    @(negedge I_CORE_CLK) I_RESET_N = 1'b0;
    repeat (2) @(negedge I_CORE_CLK);
    expect_lamps(5'h00);
    I_RESET_N = 1'b1;
    repeat (2) @(negedge I_CORE_CLK);
    expect_lamps(5'h00);
    repeat (3) @(negedge I_CORE_CLK);
    expect_lamps(expf(13'h1AC0));
    final_report();
  end
endmodule

// File: verif/sid_lamps_monitor.sv
// Port checker for the status lamp driver
module sid_lamps_monitor
  import sid_pkg::*;
(
  input wire logic       I_CORE_CLK,
  input wire logic       I_RESET_N,
  input wire logic       i_power_good,
  input wire logic       i_in_link,
  input wire logic       i_in_activity,
  input wire logic       i_out_link,
  input wire logic       i_out_activity,
  input wire logic [1:0] i_slave_state,
  input wire sid_err_t   i_err,
  input wire logic       o_power_lamp,
  input wire logic       o_in_link_lamp,
  input wire logic       o_out_link_lamp,
  input wire logic       o_run_lamp,
  input wire logic       o_err_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Five held samples cover the input latency of up to four edges
  a_power_on: assert property (i_power_good [*5] |-> o_power_lamp)
    else $error("power lamp dark");
  a_power_off: assert property (!i_power_good [*5] |-> !o_power_lamp)
    else $error("power lamp lit");
  a_in_dark: assert property (!i_in_link [*5] |-> !o_in_link_lamp)
    else $error("input lamp lit");
  a_in_steady: assert property ((i_in_link && !i_in_activity) [*5] |-> o_in_link_lamp)
    else $error("input lamp dark");
  a_out_dark: assert property (!i_out_link [*5] |-> !o_out_link_lamp)
    else $error("output lamp lit");
  a_out_steady: assert property ((i_out_link && !i_out_activity) [*5] |-> o_out_link_lamp)
    else $error("output lamp dark");
  a_run_init: assert property ((i_slave_state == SID_INIT) [*5] |-> !o_run_lamp)
    else $error("run lamp lit");
  a_run_op: assert property ((i_slave_state == SID_OP) [*5] |-> o_run_lamp)
    else $error("run lamp dark");
  a_err_none: assert property ((i_err == '0) [*5] |-> !o_err_lamp)
    else $error("error lamp lit");
  a_err_wdt: assert property (i_err.local_interface_watchdog [*5] |-> o_err_lamp)
    else $error("error lamp dark");
  c_op: cover property (o_run_lamp && i_slave_state == SID_OP);
  c_wdt: cover property (o_err_lamp && i_err.local_interface_watchdog);
  c_traffic: cover property (i_in_link && i_in_activity && !o_in_link_lamp);
endmodule
bind sid_lamps sid_lamps_monitor u_sid_lamps_monitor (.I_CORE_CLK, .I_RESET_N, .i_power_good,
  .i_in_link, .i_in_activity, .i_out_link, .i_out_activity, .i_slave_state, .i_err,
  .o_power_lamp, .o_in_link_lamp, .o_out_link_lamp, .o_run_lamp, .o_err_lamp);
